// *** core/synth_cfg_pkg.sv ***
package synth_cfg_pkg;

    // ==========================================
    // Register indices (byte address is index)
    // ==========================================
    localparam logic [7:0] FEEDBACK_DIV_UPPER_ADDR = 8'h22;
    localparam logic [7:0] FEEDBACK_DIV_LOWER_ADDR = 8'h24;
    localparam logic [7:0] SEED_ENABLE_AND_PFD_DELAY_ADDR = 8'h25;
    localparam logic [7:0] FRAC_DENOMINATOR_UPPER_ADDR = 8'h26;
    localparam logic [7:0] FRAC_DENOMINATOR_LOWER_ADDR = 8'h27;
    localparam logic [7:0] ACCUM_SEED_UPPER_ADDR = 8'h28;
    localparam logic [7:0] ACCUM_SEED_LOWER_ADDR = 8'h29;
    localparam logic [7:0] FRAC_NUMERATOR_UPPER_ADDR = 8'h2A;
    localparam logic [7:0] FRAC_NUMERATOR_LOWER_ADDR = 8'h2B;
    localparam logic [7:0] PORT_A_POWER_MODULATOR_CTRL_ADDR = 8'h2C;
    localparam logic [7:0] PORT_A_SELECT_CURRENT_PORT_B_LEVEL_ADDR = 8'h2D;
    localparam logic [7:0] PORT_B_SOURCE_SELECT_ADDR = 8'h2E;

    // ==========================================
    // Field positions
    // ==========================================
    localparam int SEED_EN_BIT = 15;
    localparam int PFD_DLY_LSB = 8;
    localparam int PORT_A_LEVEL_LSB = 8;
    localparam int PORT_B_PD_BIT = 7;
    localparam int PORT_A_PD_BIT = 6;
    localparam int MOD_RST_BIT = 5;
    localparam int MOD_ORDER_LSB = 0;
    localparam int PORT_A_SRC_LSB = 11;
    localparam int BOOST_LSB = 9;
    localparam int PORT_B_LEVEL_LSB = 0;
    localparam int PORT_B_SRC_LSB = 0;

    // ==========================================
    // Fixed constant bits of the 0x25, 0x2D and 0x2E registers
    // ==========================================
    localparam logic [15:0] SEED_PFD_FIXED = 16'h0004;
    localparam logic [15:0] PORT_A_LB_FIXED = 16'hC040;
    localparam logic [15:0] PORT_B_SRC_FIXED = 16'h07FC;

    // ==========================================
    // Reset values and the highest modulator order
    // ==========================================
    localparam logic [18:0] FB_DIV_RESET = 19'h00064;
    localparam logic [5:0] PFD_DLY_RESET = 6'h02;
    localparam logic [31:0] DEN_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] NUM_RESET = 32'h00000000;
    localparam logic [31:0] SEED_RESET = 32'h00000000;
    localparam logic [5:0] LEVEL_RESET = 6'h1F;
    localparam logic [2:0] ORDER_INTEGER = 3'h0;
    localparam logic [2:0] ORDER_MAX = 3'h4;
    localparam logic SEED_EN_RESET = 1'h0;
    localparam logic PORT_A_PD_RESET = 1'h0;
    localparam logic PORT_B_PD_RESET = 1'h1;
    localparam logic MOD_RST_RESET = 1'h1;
    localparam logic [1:0] BOOST_RESET = 2'h0;

    // ==========================================
    // Output source encodings
    // ==========================================
    typedef enum logic [1:0] {
        SRC_CHAN_DIV = 2'h0,
        SRC_OSC = 2'h1,
        SRC_REF_PULSE = 2'h2,
        SRC_HIGH_Z = 2'h3
    } port_src_e;

    // ==========================================
    // Carriers
    // ==========================================
    typedef struct packed {
        logic [18:0] feedback_div;
        logic [5:0] phase_detector_delay_select;
        logic [31:0] frac_numerator;
        logic [31:0] frac_denominator;
        logic seed_apply_enable;
        logic [31:0] accumulator_seed;
        logic modulator_run;
        logic [2:0] modulator_order;
        logic integer_mode;
    } divider_cfg_s;

    typedef struct packed {
        logic powerdown;
        logic [5:0] power_level;
        port_src_e source_select;
        logic high_z;
    } port_cfg_s;

endpackage

// *** core/synth_ndiv_modulator_output_regs.sv ***
// Notes on behaviour
// - Feedback divide is 19 bits: top 3 in one register, low 16 two registers on; reset 100.
// - Seed-enable bit at top of its register applies the seed; reset off.
// - Each seed write adds to held seed; modulator reset clears it.
// - Modulator reset low holds modulator and ignores fractions; reset to 1.
// - Order 0 integer, 1 to 4 modulator order, 5 to 7 reserved.
// - Port A power-down: 0 active, 1 powered down; reset 0.
// - Port B power-down: 0 active, 1 powered down; reset 1.
// - Port A power level 6 bits, higher gives more power; reset 31.
// - Port A source: divider, oscillator, reserved, high impedance; reset 1.
// - Output current boost: 0 maximum, 3 none; reset 0.
// - Port B power level 6 bits; reset 31.
// - Port B source: divider, oscillator, pulse generator, high impedance.
`timescale 1ns/10ps
module synth_ndiv_modulator_output_regs #(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Register port
    input wire logic [ADDR_WIDTH-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Reference pulse generator state from its own block
    input wire logic ref_pulse_gen_enable_i,
    // Configuration out
    output synth_cfg_pkg::divider_cfg_s div_cfg_o,
    output synth_cfg_pkg::port_cfg_s rf_port_a_o,
    output synth_cfg_pkg::port_cfg_s rf_port_b_o,
    output logic [1:0] output_current_boost_o,
    output logic cfg_error_o
);

    // Index must reach the top register and fit the 8-bit decode
    if (ADDR_WIDTH < 6 || ADDR_WIDTH > 8) begin : g_bad_addr_width
        $error("ADDR_WIDTH must be 6 to 8");
    end

    // ==========================================
    // State
    // ==========================================
    typedef struct packed {
        logic [18:0] feedback_div;
        logic seed_apply_enable;
        logic [5:0] phase_detector_delay_select;
        logic [31:0] frac_denominator;
        logic [31:0] accumulator_seed;
        logic [31:0] frac_numerator;
        logic [5:0] port_a_power_level;
        logic port_b_powerdown;
        logic port_a_powerdown;
        logic modulator_reset_low;
        logic [2:0] modulator_order;
        logic [1:0] port_a_source_select;
        logic [1:0] output_current_boost;
        logic [5:0] port_b_power_level;
        logic [1:0] port_b_source_select;
        logic [15:0] rdata;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic [7:0] addr;
    logic [15:0] rd_word;
    logic [31:0] seed_add;

    assign addr = 8'(reg_addr_i);

    // ==========================================
    // Read mux
    // ==========================================
    always_comb begin
        rd_word = 16'h0000;
        unique case (addr)
            synth_cfg_pkg::FEEDBACK_DIV_UPPER_ADDR: begin
                rd_word = {13'h0000, state_reg.feedback_div[18:16]};
            end
            synth_cfg_pkg::FEEDBACK_DIV_LOWER_ADDR: begin
                rd_word = state_reg.feedback_div[15:0];
            end
            synth_cfg_pkg::SEED_ENABLE_AND_PFD_DELAY_ADDR: begin
                rd_word = synth_cfg_pkg::SEED_PFD_FIXED;
                rd_word[synth_cfg_pkg::SEED_EN_BIT] = state_reg.seed_apply_enable;
                rd_word[synth_cfg_pkg::PFD_DLY_LSB +: 6] = state_reg.phase_detector_delay_select;
            end
            synth_cfg_pkg::FRAC_DENOMINATOR_UPPER_ADDR: begin
                rd_word = state_reg.frac_denominator[31:16];
            end
            synth_cfg_pkg::FRAC_DENOMINATOR_LOWER_ADDR: begin
                rd_word = state_reg.frac_denominator[15:0];
            end
            synth_cfg_pkg::ACCUM_SEED_UPPER_ADDR: begin
                rd_word = state_reg.accumulator_seed[31:16];
            end
            synth_cfg_pkg::ACCUM_SEED_LOWER_ADDR: begin
                rd_word = state_reg.accumulator_seed[15:0];
            end
            synth_cfg_pkg::FRAC_NUMERATOR_UPPER_ADDR: begin
                rd_word = state_reg.frac_numerator[31:16];
            end
            synth_cfg_pkg::FRAC_NUMERATOR_LOWER_ADDR: begin
                rd_word = state_reg.frac_numerator[15:0];
            end
            synth_cfg_pkg::PORT_A_POWER_MODULATOR_CTRL_ADDR: begin
                rd_word[synth_cfg_pkg::PORT_A_LEVEL_LSB +: 6] = state_reg.port_a_power_level;
                rd_word[synth_cfg_pkg::PORT_B_PD_BIT] = state_reg.port_b_powerdown;
                rd_word[synth_cfg_pkg::PORT_A_PD_BIT] = state_reg.port_a_powerdown;
                rd_word[synth_cfg_pkg::MOD_RST_BIT] = state_reg.modulator_reset_low;
                rd_word[synth_cfg_pkg::MOD_ORDER_LSB +: 3] = state_reg.modulator_order;
            end
            synth_cfg_pkg::PORT_A_SELECT_CURRENT_PORT_B_LEVEL_ADDR: begin
                rd_word = synth_cfg_pkg::PORT_A_LB_FIXED;
                rd_word[synth_cfg_pkg::PORT_A_SRC_LSB +: 2] = state_reg.port_a_source_select;
                rd_word[synth_cfg_pkg::BOOST_LSB +: 2] = state_reg.output_current_boost;
                rd_word[synth_cfg_pkg::PORT_B_LEVEL_LSB +: 6] = state_reg.port_b_power_level;
            end
            synth_cfg_pkg::PORT_B_SOURCE_SELECT_ADDR: begin
                rd_word = synth_cfg_pkg::PORT_B_SRC_FIXED;
                rd_word[synth_cfg_pkg::PORT_B_SRC_LSB +: 2] = state_reg.port_b_source_select;
            end
            // Unmapped addresses read zero
            default: begin
                rd_word = 16'h0000;
            end
        endcase
    end

    // ==========================================
    // Next state
    // ==========================================
    always_comb begin
        state_next = state_reg;
        seed_add = 32'h00000000;
        state_next.rdata = reg_rd_i ? rd_word : 16'h0000;
        if (reg_wr_i) begin
            unique case (addr)
                synth_cfg_pkg::FEEDBACK_DIV_UPPER_ADDR: begin
                    state_next.feedback_div[18:16] = reg_wdata_i[2:0];
                end
                synth_cfg_pkg::FEEDBACK_DIV_LOWER_ADDR: begin
                    state_next.feedback_div[15:0] = reg_wdata_i;
                end
                synth_cfg_pkg::SEED_ENABLE_AND_PFD_DELAY_ADDR: begin
                    state_next.seed_apply_enable = reg_wdata_i[synth_cfg_pkg::SEED_EN_BIT];
                    state_next.phase_detector_delay_select =
                        reg_wdata_i[synth_cfg_pkg::PFD_DLY_LSB +: 6];
                end
                synth_cfg_pkg::FRAC_DENOMINATOR_UPPER_ADDR: begin
                    state_next.frac_denominator[31:16] = reg_wdata_i;
                end
                synth_cfg_pkg::FRAC_DENOMINATOR_LOWER_ADDR: begin
                    state_next.frac_denominator[15:0] = reg_wdata_i;
                end
                synth_cfg_pkg::ACCUM_SEED_UPPER_ADDR: begin
                    seed_add = {reg_wdata_i, 16'h0000};
                end
                synth_cfg_pkg::ACCUM_SEED_LOWER_ADDR: begin
                    seed_add = {16'h0000, reg_wdata_i};
                end
                synth_cfg_pkg::FRAC_NUMERATOR_UPPER_ADDR: begin
                    state_next.frac_numerator[31:16] = reg_wdata_i;
                end
                synth_cfg_pkg::FRAC_NUMERATOR_LOWER_ADDR: begin
                    state_next.frac_numerator[15:0] = reg_wdata_i;
                end
                synth_cfg_pkg::PORT_A_POWER_MODULATOR_CTRL_ADDR: begin
                    state_next.port_a_power_level = reg_wdata_i[synth_cfg_pkg::PORT_A_LEVEL_LSB +: 6];
                    state_next.port_b_powerdown = reg_wdata_i[synth_cfg_pkg::PORT_B_PD_BIT];
                    state_next.port_a_powerdown = reg_wdata_i[synth_cfg_pkg::PORT_A_PD_BIT];
                    state_next.modulator_reset_low = reg_wdata_i[synth_cfg_pkg::MOD_RST_BIT];
                    state_next.modulator_order = reg_wdata_i[synth_cfg_pkg::MOD_ORDER_LSB +: 3];
                end
                synth_cfg_pkg::PORT_A_SELECT_CURRENT_PORT_B_LEVEL_ADDR: begin
                    state_next.port_a_source_select =
                        reg_wdata_i[synth_cfg_pkg::PORT_A_SRC_LSB +: 2];
                    state_next.output_current_boost = reg_wdata_i[synth_cfg_pkg::BOOST_LSB +: 2];
                    state_next.port_b_power_level =
                        reg_wdata_i[synth_cfg_pkg::PORT_B_LEVEL_LSB +: 6];
                end
                synth_cfg_pkg::PORT_B_SOURCE_SELECT_ADDR: begin
                    state_next.port_b_source_select =
                        reg_wdata_i[synth_cfg_pkg::PORT_B_SRC_LSB +: 2];
                end
                default: begin
                    state_next.rdata = state_next.rdata;
                end
            endcase
        end
        state_next.accumulator_seed = state_reg.accumulator_seed + seed_add;
        if (!state_reg.modulator_reset_low) begin
            state_next.accumulator_seed = synth_cfg_pkg::SEED_RESET;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg.feedback_div <= synth_cfg_pkg::FB_DIV_RESET;
            state_reg.seed_apply_enable <= synth_cfg_pkg::SEED_EN_RESET;
            state_reg.phase_detector_delay_select <= synth_cfg_pkg::PFD_DLY_RESET;
            state_reg.frac_denominator <= synth_cfg_pkg::DEN_RESET;
            state_reg.accumulator_seed <= synth_cfg_pkg::SEED_RESET;
            state_reg.frac_numerator <= synth_cfg_pkg::NUM_RESET;
            state_reg.port_a_power_level <= synth_cfg_pkg::LEVEL_RESET;
            state_reg.port_b_powerdown <= synth_cfg_pkg::PORT_B_PD_RESET;
            state_reg.port_a_powerdown <= synth_cfg_pkg::PORT_A_PD_RESET;
            state_reg.modulator_reset_low <= synth_cfg_pkg::MOD_RST_RESET;
            state_reg.modulator_order <= synth_cfg_pkg::ORDER_INTEGER;
            state_reg.port_a_source_select <= synth_cfg_pkg::SRC_OSC;
            state_reg.output_current_boost <= synth_cfg_pkg::BOOST_RESET;
            state_reg.port_b_power_level <= synth_cfg_pkg::LEVEL_RESET;
            state_reg.port_b_source_select <= synth_cfg_pkg::SRC_OSC;
            state_reg.rdata <= 16'h0000;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    // ==========================================
    // Outputs
    // ==========================================
    assign reg_rdata_o = state_reg.rdata;
    assign output_current_boost_o = state_reg.output_current_boost;

    always_comb begin
        div_cfg_o.feedback_div = state_reg.feedback_div;
        div_cfg_o.phase_detector_delay_select = state_reg.phase_detector_delay_select;
        div_cfg_o.frac_numerator = state_reg.modulator_reset_low ?
            state_reg.frac_numerator : 32'h00000000;
        div_cfg_o.frac_denominator = state_reg.frac_denominator;
        div_cfg_o.seed_apply_enable = state_reg.seed_apply_enable;
        div_cfg_o.accumulator_seed = state_reg.seed_apply_enable ?
            state_reg.accumulator_seed : 32'h00000000;
        div_cfg_o.modulator_run = state_reg.modulator_reset_low;
        // Reserved orders fall back to integer
        div_cfg_o.modulator_order = (state_reg.modulator_order > synth_cfg_pkg::ORDER_MAX) ?
            synth_cfg_pkg::ORDER_INTEGER : state_reg.modulator_order;
        div_cfg_o.integer_mode = (div_cfg_o.modulator_order == synth_cfg_pkg::ORDER_INTEGER);
        rf_port_a_o.powerdown = state_reg.port_a_powerdown;
        rf_port_a_o.power_level = state_reg.port_a_power_level;
        rf_port_a_o.source_select = synth_cfg_pkg::port_src_e'(state_reg.port_a_source_select);
        rf_port_a_o.high_z = (state_reg.port_a_source_select[1]);
        rf_port_b_o.powerdown = state_reg.port_b_powerdown;
        rf_port_b_o.power_level = state_reg.port_b_power_level;
        rf_port_b_o.source_select = synth_cfg_pkg::port_src_e'(state_reg.port_b_source_select);
        rf_port_b_o.high_z = (state_reg.port_b_source_select == synth_cfg_pkg::SRC_HIGH_Z) ||
            ((state_reg.port_b_source_select == synth_cfg_pkg::SRC_REF_PULSE) &&
             !ref_pulse_gen_enable_i);
        cfg_error_o = (state_reg.modulator_order > synth_cfg_pkg::ORDER_MAX) ||
            (state_reg.port_a_source_select == synth_cfg_pkg::SRC_REF_PULSE);
    end

endmodule // synth_ndiv_modulator_output_regs

// *** tb/synth_regs_props.sv ***
`timescale 1ns/10ps
// ==========================================
// Port checker
// ==========================================
module synth_regs_props #(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and register port
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [ADDR_WIDTH-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // Configuration
    input wire logic ref_pulse_gen_enable_i,
    input wire synth_cfg_pkg::divider_cfg_s div_cfg_o,
    input wire synth_cfg_pkg::port_cfg_s rf_port_a_o,
    input wire synth_cfg_pkg::port_cfg_s rf_port_b_o,
    input wire logic [1:0] output_current_boost_o,
    input wire logic cfg_error_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // Write taken only with the enable high
    sequence s_wr(a);
        reg_wr_i && clk_en_i && reg_addr_i == a;
    endsequence

    a_div_low: assert property (s_wr(8'h24) |=>
        div_cfg_o.feedback_div[15:0] == $past(reg_wdata_i)) else $error("low divide wrong");
    a_div_high: assert property (s_wr(8'h22) |=>
        div_cfg_o.feedback_div[18:16] == $past(reg_wdata_i[2:0])) else $error("high divide wrong");
    a_seed_adds: assert property (s_wr(8'h29) ##0 div_cfg_o.seed_apply_enable
        && div_cfg_o.modulator_run |=> div_cfg_o.accumulator_seed ==
        $past(div_cfg_o.accumulator_seed) + {16'h0000, $past(reg_wdata_i)})
        else $error("seed did not accumulate");
    a_seed_clear: assert property ($past(!div_cfg_o.modulator_run && clk_en_i) |->
        div_cfg_o.accumulator_seed == 32'h0) else $error("seed not cleared");
    a_frac_ignored: assert property (!div_cfg_o.modulator_run |->
        div_cfg_o.frac_numerator == 32'h0) else $error("numerator not ignored");
    a_order_map: assert property (s_wr(8'h2C) |=> div_cfg_o.modulator_order ==
        ($past(reg_wdata_i[2:0]) > 3'h4 ? 3'h0 : $past(reg_wdata_i[2:0]))
        && div_cfg_o.integer_mode == (div_cfg_o.modulator_order == 3'h0))
        else $error("order mapping wrong");
    a_order_error: assert property (s_wr(8'h2C) ##0 !rf_port_a_o.high_z |=>
        cfg_error_o == ($past(reg_wdata_i[2:0]) > 3'h4)) else $error("order flag wrong");
    a_pd_write: assert property (s_wr(8'h2C) |=>
        rf_port_a_o.powerdown == $past(reg_wdata_i[6])
        && rf_port_b_o.powerdown == $past(reg_wdata_i[7])) else $error("powerdown wrong");
    a_port_a_fields: assert property (s_wr(8'h2D) |=>
        rf_port_a_o.high_z == $past(reg_wdata_i[12])
        && output_current_boost_o == $past(reg_wdata_i[10:9])
        && rf_port_b_o.power_level == $past(reg_wdata_i[5:0])) else $error("field wrong");
    a_port_b_hz: assert property (s_wr(8'h2E) |=>
        rf_port_b_o.source_select == $past(reg_wdata_i[1:0])
        && rf_port_b_o.high_z == ($past(reg_wdata_i[1:0]) == 2'h3
        || ($past(reg_wdata_i[1:0]) == 2'h2 && !ref_pulse_gen_enable_i)))
        else $error("port B high_z wrong");
    a_read_b: assert property (reg_rd_i && clk_en_i && reg_addr_i == 8'h2E |=>
        reg_rdata_o == (16'h07FC | {14'h0000, rf_port_b_o.source_select}))
        else $error("port B readback wrong");
endmodule // synth_regs_props

bind synth_ndiv_modulator_output_regs synth_regs_props #(.ADDR_WIDTH(ADDR_WIDTH)) props_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ref_pulse_gen_enable_i(ref_pulse_gen_enable_i),
    .div_cfg_o(div_cfg_o), .rf_port_a_o(rf_port_a_o), .rf_port_b_o(rf_port_b_o),
    .output_current_boost_o(output_current_boost_o), .cfg_error_o(cfg_error_o));

// *** tb/tb_synth_ndiv_modulator_output_regs.sv ***
`timescale 1ns/10ps
module tb_synth_ndiv_modulator_output_regs;
    // ==========================================
    // Signals and tables
    // ==========================================
    logic ref_clk_i, reset_i, clk_en_i, reg_wr_i, reg_rd_i, ref_pulse_gen_enable_i, cfg_error_o;
    logic [7:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, rd_val;
    logic [1:0] output_current_boost_o;
    synth_cfg_pkg::divider_cfg_s div_cfg_o;
    synth_cfg_pkg::port_cfg_s rf_port_a_o, rf_port_b_o;
    int err_count, n_compared;
    localparam logic [23:0] RST_ROWS [12] = '{24'h220000, 24'h240064, 24'h250204,
        24'h26FFFF, 24'h27FFFF, 24'h280000, 24'h290000, 24'h2A0000, 24'h2B0000,
        24'h2C1FA0, 24'h2DC85F, 24'h2E07FD};
    // Address, write data, readback
    localparam logic [39:0] WR_ROWS [10] = '{40'h22FFFF0007, 40'h2412341234, 40'h25FFFFBF04,
        40'h26ABCDABCD, 40'h2756785678, 40'h2A13571357, 40'h2B24682468, 40'h2CFFBB3FA3,
        40'h2D0000C040, 40'h2E000207FE};

    synth_ndiv_modulator_output_regs synth_ndiv_modulator_output_regs_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .ref_pulse_gen_enable_i(ref_pulse_gen_enable_i),
        .div_cfg_o(div_cfg_o), .rf_port_a_o(rf_port_a_o), .rf_port_b_o(rf_port_b_o),
        .output_current_boost_o(output_current_boost_o), .cfg_error_o(cfg_error_o));

    // ==========================================
    // Tasks
    // ==========================================
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    // Strobe dropped one edge later, so back-to-back calls never double-drive
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        rd_val = reg_rdata_o;
    endtask
    task automatic conclude();
        $display("Counts: %0d compared, %0d mismatches", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Clock and watchdog
    // ==========================================
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // Tests need under 200 cycles; allow 20000
    initial begin
        #100000;
        err_count++;
        conclude();
    end

    // ==========================================
    // Tests
    // ==========================================
    initial begin
        err_count = 0;
        n_compared = 0;
        reset_i = 1'b1;
        clk_en_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        ref_pulse_gen_enable_i = 1'b0;
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        #1;
        chk("divide", 32'h64, div_cfg_o.feedback_div);
        chk("seed_en", 32'h0, div_cfg_o.seed_apply_enable);
        chk("a_pd", 32'h0, rf_port_a_o.powerdown);
        chk("b_pd", 32'h1, rf_port_b_o.powerdown);
        foreach (RST_ROWS[i]) begin
            rd(RST_ROWS[i][23:16]);
            chk("reset read", RST_ROWS[i][15:0], rd_val);
        end
        $display("Test reset done");
        foreach (WR_ROWS[i]) begin
            wr(WR_ROWS[i][39:32], WR_ROWS[i][31:16]);
            rd(WR_ROWS[i][39:32]);
            chk("readback", WR_ROWS[i][15:0], rd_val);
        end
        chk("divide", 32'h71234, div_cfg_o.feedback_div);
        chk("pfd", 32'h3F, div_cfg_o.phase_detector_delay_select);
        chk("den", 32'hABCD5678, div_cfg_o.frac_denominator);
        chk("a_level", 32'h3F, rf_port_a_o.power_level);
        $display("Test rows done");
        wr(8'h29, 16'hF000);
        wr(8'h29, 16'h2000);
        chk("seed", 32'h11000, div_cfg_o.accumulator_seed);
        wr(8'h28, 16'hFFFF);
        chk("seed wrap", 32'h1000, div_cfg_o.accumulator_seed);
        wr(8'h2C, 16'h3F83);
        @(posedge ref_clk_i);
        #1;
        chk("seed held", 32'h0, div_cfg_o.accumulator_seed);
        chk("num held", 32'h0, div_cfg_o.frac_numerator);
        chk("run", 32'h0, div_cfg_o.modulator_run);
        wr(8'h29, 16'h0005);
        chk("seed clear wins", 32'h0, div_cfg_o.accumulator_seed);
        wr(8'h2C, 16'h3FA3);
        chk("num", 32'h13572468, div_cfg_o.frac_numerator);
        wr(8'h25, 16'h3F04);
        wr(8'h29, 16'h0007);
        chk("seed off", 32'h0, div_cfg_o.accumulator_seed);
        wr(8'h25, 16'hBF04);
        chk("seed on", 32'h7, div_cfg_o.accumulator_seed);
        $display("Test seed done");
        wr(8'h2C, 16'h3F63);
        chk("a_pd", 32'h1, rf_port_a_o.powerdown);
        chk("b_pd", 32'h0, rf_port_b_o.powerdown);
        for (int i = 0; i < 8; i++) begin
            wr(8'h2C, 16'h3FA0 | 16'(i));
            chk("order", (i > 4) ? 32'h0 : 32'(i), div_cfg_o.modulator_order);
            chk("int", 32'(i == 0 || i > 4), div_cfg_o.integer_mode);
            chk("err", 32'(i > 4), cfg_error_o);
        end
        wr(8'h2C, 16'h3FA3);
        for (int i = 0; i < 4; i++) begin
            wr(8'h2D, 16'h0615 | 16'(i << 11));
            chk("a_hz", 32'(i >= 2), rf_port_a_o.high_z);
            chk("a_src", 32'(i), rf_port_a_o.source_select);
            chk("a_err", 32'(i == 2), cfg_error_o);
            chk("boost", 32'h3, output_current_boost_o);
            chk("b_level", 32'h15, rf_port_b_o.power_level);
        end
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                @(posedge ref_clk_i);
                ref_pulse_gen_enable_i <= p[0];
                wr(8'h2E, 16'(i));
                chk("b_src", 32'(i), rf_port_b_o.source_select);
                chk("b_hz", 32'(i == 3 || (i == 2 && p == 0)), rf_port_b_o.high_z);
            end
        end
        $display("Test ports done");
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        wr(8'h24, 16'hBEEF);
        clk_en_i <= 1'b1;
        rd(8'h24);
        chk("frozen", 32'h1234, rd_val);
        wr(8'h23, 16'hFFFF);
        rd(8'h23);
        chk("unmapped", 32'h0, rd_val);
        rd(8'h2F);
        chk("unmapped", 32'h0, rd_val);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= 8'h24;
        reg_wdata_i <= 16'h4321;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("back to back", 32'h4321, reg_rdata_o);
        @(posedge ref_clk_i);
        #1;
        chk("rdata idle", 32'h0, reg_rdata_o);
        // Reset must win even with the enable low
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        reset_i <= 1'b1;
        @(posedge ref_clk_i);
        reset_i <= 1'b0;
        clk_en_i <= 1'b1;
        #1;
        chk("mid reset divide", 32'h64, div_cfg_o.feedback_div);
        chk("mid reset a_src", 32'h1, rf_port_a_o.source_select);
        chk("mid reset b_src", 32'h1, rf_port_b_o.source_select);
        rd(8'h2C);
        chk("mid reset read", 32'h1FA0, rd_val);
        $display("Test awkward done");
        conclude();
    end
endmodule // tb_synth_ndiv_modulator_output_regs
